/* core/strobe_dll_delay_control.sv */
// delay-locked loop control: compare, count, lock wait and strobe routing
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module strobe_dll_delay_control
   import strobe_dll_pkg::*;
#(
   parameter int LOCK_CYCLES = LOCK_REF_CYCLES,
   parameter int CHAIN_MAX   = MAX_ELEMENTS
) (
   input  wire logic               clk,
   input  wire logic               rstn,
   input  wire logic               ref_from_pll,     // reference source select
   input  wire logic               ref_pll_clk,      // sampled reference levels
   input  wire logic               ref_pin_clk,
   input  wire logic               chain_out,        // last chain element output
   input  wire logic               fabric_reset,
   input  wire logic               pin_reset,
   input  wire freq_mode_type      freq_mode,
   input  wire logic               zero_shift,
   input  wire logic               use_ioe_resync,
   input  wire logic               qdr_mode,
   input  wire logic               strobe_in,
   input  wire logic               strobe_shifted,   // from external delay chain
   input  wire logic               cq_n_shifted,
   input  wire logic [6:0]         offset_in,        // sign plus magnitude, gray
   output logic                    ref_to_chain,
   output logic [4:0]              chain_length,
   output setting_fanout_type      setting_out,
   output logic [6:0]              offset_to_strobe,
   output strobe_route_type        route,
   output logic                    locked
);
   // ------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------
   initial begin
      if (CHAIN_MAX > MAX_ELEMENTS || CHAIN_MAX < 8) $error("chain length unsupported");
      if (LOCK_CYCLES < 1) $error("lock count too small");
   end

   // ------------------------------------------------------------
   // reset synchroniser
   // ------------------------------------------------------------
   logic rst_meta;
   logic rst_sync;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   // loop reset from either source, registered so outputs stay flop-driven
   logic loop_reset;
   logic next_loop_reset;
   always_comb begin
      next_loop_reset = fabric_reset | pin_reset;
   end

   // ------------------------------------------------------------
   // reference selection and phase comparison
   // ------------------------------------------------------------
   logic ref_sel;
   logic next_ref_sel;
   logic ref_prev;
   logic step;
   logic up;
   logic next_step;
   logic next_up;
   logic [5:0] max_code;
   logic [5:0] gray;

   always_comb begin
      next_ref_sel = ref_from_pll ? ref_pll_clk : ref_pin_clk;
      // at each reference rise, a low chain output means delay too short
      next_step = ref_sel & ~ref_prev & ~loop_reset;
      next_up   = ~chain_out;
      max_code  = (freq_mode >= MODE_HALF_FIRST) ? MAX_CODE_HALF : MAX_CODE_FULL;
   end

   always_ff @(posedge clk or negedge rst_sync) begin
      if (!rst_sync) begin
         loop_reset <= 1'b1;
         ref_sel    <= 1'b0;
         ref_prev   <= 1'b0;
         step       <= 1'b0;
         up         <= 1'b0;
      end else begin
         loop_reset <= next_loop_reset;
         ref_sel    <= next_ref_sel;
         ref_prev   <= ref_sel;
         step       <= next_step;
         up         <= next_up;
      end
   end

   // counter resets with the loop as well as the device
   logic cnt_rst_n;
   assign cnt_rst_n = rst_sync & ~loop_reset;

   gray_step_counter #(
      .WIDTH (SETTING_W)
   ) u_counter (
      .clk     (clk),
      .rst_n   (cnt_rst_n),
      .step    (step),
      .up      (up),
      .max_bin (max_code),
      .gray    (gray)
   );

   // ------------------------------------------------------------
   // lock wait counter in reference cycles
   // ------------------------------------------------------------
   localparam int LOCK_W = $clog2(LOCK_CYCLES+1);
   logic [LOCK_W-1:0] lock_cnt;
   logic [LOCK_W-1:0] next_lock_cnt;
   logic next_locked;

   always_comb begin
      next_lock_cnt = lock_cnt;
      next_locked   = locked;
      if (loop_reset) begin
         next_lock_cnt = '0;
         next_locked   = 1'b0;
      end else if (ref_sel && !ref_prev && !locked) begin
         next_lock_cnt = lock_cnt + 1'b1;
         if (lock_cnt == LOCK_W'(LOCK_CYCLES - 1)) begin
            next_locked = 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // output registers: fanout, chain length, routing
   // ------------------------------------------------------------
   setting_fanout_type next_setting;
   strobe_route_type   next_route;
   logic [6:0]         next_offset;
   logic [4:0]         next_chain;
   logic               shifted;

   always_comb begin
      // modes 4-7 keep the top bit at zero
      next_setting.fabric       = (freq_mode >= MODE_HALF_FIRST) ? {1'b0, gray[4:0]} : gray;
      next_setting.strobe_logic = next_setting.fabric;
      next_setting.leveling     = next_setting.fabric;
      next_offset = offset_in;
      next_chain  = mode_elements((freq_mode > MODE_LAST) ? MODE_LAST : freq_mode);
      if (next_chain > 5'(CHAIN_MAX)) begin
         next_chain = 5'(CHAIN_MAX);
      end
      // zero-degree strobe goes straight through, no loop involvement
      shifted = zero_shift ? strobe_in : strobe_shifted;
      next_route.capture_clk = shifted;
      next_route.fabric_clk  = use_ioe_resync ? 1'b0 : shifted;
      next_route.neg_capture = qdr_mode ? cq_n_shifted : 1'b0;
   end

   always_ff @(posedge clk or negedge rst_sync) begin
      if (!rst_sync) begin
         lock_cnt         <= '0;
         locked           <= 1'b0;
         setting_out      <= '0;
         offset_to_strobe <= 7'h00;
         chain_length     <= CHAIN_RESET;
         route            <= '0;
         ref_to_chain     <= 1'b0;
      end else begin
         lock_cnt         <= next_lock_cnt;
         locked           <= next_locked;
         setting_out      <= next_setting;
         offset_to_strobe <= next_offset;
         chain_length     <= next_chain;
         route            <= next_route;
         ref_to_chain     <= ref_sel;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_half_top_bit: assert property (@(posedge clk) disable iff (!rst_sync)
      $past(freq_mode) >= MODE_HALF_FIRST |-> setting_out.fabric[5] == 1'b0)
      else $error("top bit set in half-width mode");
   a_fanout_equal: assert property (@(posedge clk) disable iff (!rst_sync)
      setting_out.fabric == setting_out.leveling && setting_out.fabric == setting_out.strobe_logic)
      else $error("setting fanout mismatch");
   a_reset_unlock: assert property (@(posedge clk) disable iff (!rst_sync)
      loop_reset |=> !locked)
      else $error("lock held through loop reset");
   a_lock_early: assert property (@(posedge clk) disable iff (!rst_sync)
      $rose(locked) |-> lock_cnt == LOCK_W'(LOCK_CYCLES))
      else $error("lock asserted at wrong count");
   a_reset_source: assert property (@(posedge clk) disable iff (!rst_sync)
      (fabric_reset || pin_reset) |=> loop_reset)
      else $error("reset request ignored");
   a_zero_bypass: assert property (@(posedge clk) disable iff (!rst_sync)
      zero_shift |=> route.capture_clk == $past(strobe_in))
      else $error("zero shift not bypassed");
   a_qdr_only: assert property (@(posedge clk) disable iff (!rst_sync)
      !qdr_mode |=> !route.neg_capture)
      else $error("negative capture outside qdr");
   a_resync_gate: assert property (@(posedge clk) disable iff (!rst_sync)
      use_ioe_resync |=> !route.fabric_clk)
      else $error("fabric strobe while resync in use");
   a_chain_bound: assert property (@(posedge clk) disable iff (!rst_sync)
      chain_length <= 5'h10)
      else $error("chain longer than sixteen");
   a_offset_route: assert property (@(posedge clk) disable iff (!rst_sync)
      offset_to_strobe == $past(offset_in))
      else $error("offset not forwarded");

   c_lock_reached: cover property (@(posedge clk) disable iff (!rst_sync) $rose(locked));
   c_step_up:      cover property (@(posedge clk) disable iff (!rst_sync) step && up);
   c_step_down:    cover property (@(posedge clk) disable iff (!rst_sync) step && !up);
   c_half_mode:    cover property (@(posedge clk) disable iff (!rst_sync) freq_mode == 3'h4 && locked);
endmodule // strobe_dll_delay_control
`default_nettype wire

/* include/strobe_dll_pkg.sv */
// shared constants and types for the strobe delay-locked loop
package strobe_dll_pkg;
   // ------------------------------------------------------------
   // timing and widths
   // ------------------------------------------------------------
   localparam int          SETTING_W      = 6;
   localparam int          MAX_ELEMENTS   = 16;
   localparam int          LOCK_REF_CYCLES = 1280;
   localparam logic [5:0]  SETTING_RESET  = 6'h00;
   localparam logic [4:0]  CHAIN_RESET    = 5'h10;
   localparam logic [5:0]  MAX_CODE_FULL  = 6'h3F;
   localparam logic [5:0]  MAX_CODE_HALF  = 6'h1F;
   localparam logic [2:0]  MODE_LAST      = 3'h6;
   localparam logic [2:0]  MODE_HALF_FIRST = 3'h4;

   // ------------------------------------------------------------
   // modes and strobe routing
   // ------------------------------------------------------------
   typedef logic [2:0] freq_mode_type;

   typedef struct packed {
      logic capture_clk;   // shifted strobe to capture registers
      logic fabric_clk;    // shifted strobe to fabric resync
      logic neg_capture;   // complementary clock, negative-edge register
   } strobe_route_type;

   typedef struct packed {
      logic [5:0] fabric;
      logic [5:0] strobe_logic;
      logic [5:0] leveling;
   } setting_fanout_type;

   // elements used for a mode
   function automatic logic [4:0] mode_elements(input freq_mode_type m);
      case (m)
         3'h0:      mode_elements = 5'h10;
         3'h1,3'h4: mode_elements = 5'h0C;
         3'h2,3'h5: mode_elements = 5'h0A;
         default:   mode_elements = 5'h08;
      endcase
   endfunction
endpackage

/* core/gray_step_counter.sv */
// gray-coded saturating up/down delay counter
`timescale 1ns/1ps
`default_nettype none
module gray_step_counter
   import strobe_dll_pkg::*;
#(
   parameter int WIDTH = SETTING_W
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             step,
   input  wire logic             up,
   input  wire logic [WIDTH-1:0] max_bin,
   output logic      [WIDTH-1:0] gray
);
   initial begin
      if (WIDTH < 2) $error("width too small");
   end

   logic [WIDTH-1:0] bin;
   logic [WIDTH-1:0] next_bin;

   // saturate instead of wrapping; if the limit drops on a mode change,
   // walk down one code a cycle so the gray output never jumps two bits
   always_comb begin
      next_bin = bin;
      if (bin > max_bin) begin
         next_bin = bin - 1'b1;
      end else if (step && up && bin != max_bin) begin
         next_bin = bin + 1'b1;
      end else if (step && !up && bin != '0) begin
         next_bin = bin - 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bin  <= '0;
         gray <= '0;
      end else begin
         bin  <= next_bin;
         gray <= next_bin ^ (next_bin >> 1);
      end
   end

   a_gray_one_bit: assert property (@(posedge clk) disable iff (!rst_n)
      $countones(gray ^ $past(gray)) <= 1)
      else $error("gray code moved more than one bit");
   a_count_no_wrap: assert property (@(posedge clk) disable iff (!rst_n)
      (bin == '0 && step && !up && max_bin != '0) |=> bin == '0)
      else $error("counter wrapped below zero");
endmodule // gray_step_counter
`default_nettype wire

/* testbench/delay_chain_model.sv */
// behavioural delay chain and reference source facing the loop
`timescale 1ns/1ps
`default_nettype none
module delay_chain_model (
   input  wire logic       clk,
   input  wire logic       run,
   input  wire logic [5:0] setting,
   input  wire logic [6:0] target,
   output logic            ref_clk,
   output logic            chain_out
);
   // ------------------------------------------------------------
   // reference and chain
   // ------------------------------------------------------------
   logic [2:0] div;
   logic [5:0] bin;

   // one reference rate for every strobe; parks low when stopped
   always_ff @(posedge clk) begin
      if (!run) begin
         div     <= 3'h0;
         ref_clk <= 1'b0;
      end else begin
         div <= div + 3'h1;
         if (div == 3'h3)
            ref_clk <= ~ref_clk;
      end
   end

   // chain too short while setting below target; 7'h40 forces up
   always_comb begin
      bin[5] = setting[5];
      for (int i = 4; i >= 0; i--)
         bin[i] = bin[i+1] ^ setting[i];
      chain_out = ({1'b0, bin} >= target);
   end
endmodule // delay_chain_model
`default_nettype wire

/* testbench/test_strobe_dll_delay_control.sv */
// self-checking bench for the strobe delay-locked loop control
`timescale 1ns/1ps
`default_nettype none
module test_strobe_dll_delay_control;
   import strobe_dll_pkg::*;
   // ------------------------------------------------------------
   // signals, tasks and watchers
   // ------------------------------------------------------------
   logic clk = 1'b0, rstn = 1'b0, run = 1'b0, gray_watch = 1'b0;
   logic ref_from_pll = 1'b1, ref_pin_clk = 1'b0, fabric_reset = 1'b0, pin_reset = 1'b0;
   logic zero_shift = 1'b0, use_ioe_resync = 1'b0, qdr_mode = 1'b0;
   logic strobe_in = 1'b0, strobe_shifted = 1'b0, cq_n_shifted = 1'b0;
   logic ref_clk, chain_out, ref_to_chain, locked;
   freq_mode_type freq_mode = 3'h0;
   logic [6:0] offset_in = 7'h00, target = 7'h40, offset_to_strobe;
   logic [4:0] chain_length;
   logic [5:0] prev_set = 6'h00;
   logic [31:0] rnd, exp_val;
   setting_fanout_type setting_out;
   strobe_route_type route;
   logic [34:0] notes[$];
   int errors = 0, checks = 0, seed = 41;
   int len_tab[8] = '{16, 12, 10, 8, 12, 10, 8, 8};
   event result_ev;

   always #5 clk = ~clk;

   strobe_dll_delay_control #(.LOCK_CYCLES(8)) strobe_dll_delay_control_inst (
      .clk(clk), .rstn(rstn), .ref_from_pll(ref_from_pll), .ref_pll_clk(ref_clk),
      .ref_pin_clk(ref_pin_clk), .chain_out(chain_out), .fabric_reset(fabric_reset),
      .pin_reset(pin_reset), .freq_mode(freq_mode), .zero_shift(zero_shift),
      .use_ioe_resync(use_ioe_resync), .qdr_mode(qdr_mode), .strobe_in(strobe_in),
      .strobe_shifted(strobe_shifted), .cq_n_shifted(cq_n_shifted), .offset_in(offset_in),
      .ref_to_chain(ref_to_chain), .chain_length(chain_length), .setting_out(setting_out),
      .offset_to_strobe(offset_to_strobe), .route(route), .locked(locked));

   delay_chain_model delay_chain_model_inst (
      .clk(clk), .run(run), .setting(setting_out.strobe_logic), .target(target),
      .ref_clk(ref_clk), .chain_out(chain_out));

   function automatic logic [5:0] gray2bin(input logic [5:0] g);
      logic [5:0] b;
      b[5] = g[5];
      for (int i = 4; i >= 0; i--)
         b[i] = b[i+1] ^ g[i];
      return b;
   endfunction

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("FAIL at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   // note the expectation; outputs are settled at this falling edge
   task automatic expect_now(input logic [2:0] kind, input logic [31:0] val);
      notes.push_back({kind, val});
      -> result_ev;
   endtask

   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // oldest note against what the outputs show now
   always begin : watch_outputs
      logic [34:0] n;
      @(result_ev);
      while (notes.size() > 0) begin
         n = notes.pop_front();
         case (n[34:32])
            3'h0: check({21'h0, route, offset_to_strobe, ref_to_chain}, n[31:0]);
            3'h1: check({27'h0, chain_length}, n[31:0]);
            3'h2: check({26'h0, gray2bin(setting_out.fabric)}, n[31:0]);
            default: check({31'h0, locked}, n[31:0]);
         endcase
      end
   end

   // every step moves one bit and reaches all three consumers
   always @(posedge clk) begin : watch_gray
      if (rstn && gray_watch && setting_out.fabric !== prev_set)
         check({31'h0, $countones(setting_out.fabric ^ prev_set) == 1}, 32'h1);
      if (rstn && gray_watch)
         check({20'h0, setting_out.strobe_logic, setting_out.leveling}, {20'h0, {2{setting_out.fabric}}});
      prev_set <= setting_out.fabric;
   end

   // about 2700 cycles expected; generous margin
   initial begin : watchdog
      repeat (20000) @(posedge clk);
      errors++;
      report_and_stop();
   end

   initial begin : main
      repeat (3) @(negedge clk);
      expect_now(3'h1, 32'h10);
      expect_now(3'h2, 32'h0);
      expect_now(3'h3, 32'h0);
      repeat (13) @(negedge clk);
      rstn = 1'b1;
      run = 1'b1;
      repeat (8) @(negedge clk);
      gray_watch = 1'b1;
      repeat (56) @(negedge clk);
      expect_now(3'h3, 32'h0);
      repeat (140) @(negedge clk);
      expect_now(3'h3, 32'h1);
      // loop reset from fabric, then from the pin; counter jumps to zero
      for (int s = 0; s < 2; s++) begin
         gray_watch = 1'b0;
         fabric_reset = (s == 0);
         pin_reset = (s == 1);
         repeat (4) @(negedge clk);
         expect_now(3'h3, 32'h0);
         expect_now(3'h2, 32'h0);
         fabric_reset = 1'b0;
         pin_reset = 1'b0;
         repeat (4) @(negedge clk);
         gray_watch = 1'b1;
         repeat (200) @(negedge clk);
         expect_now(3'h3, 32'h1);
      end
      // saturate high, clamp to five bits, saturate low
      repeat (1200) @(negedge clk);
      expect_now(3'h2, 32'h3F);
      gray_watch = 1'b0;
      freq_mode = 3'h4;
      repeat (8) @(negedge clk);
      gray_watch = 1'b1;
      repeat (100) @(negedge clk);
      expect_now(3'h2, 32'h1F);
      target = 7'h00;
      repeat (700) @(negedge clk);
      expect_now(3'h2, 32'h0);
      // mode 7 is not a real mode; it must fall back to the shortest chain
      for (int m = 0; m < 8; m++) begin
         freq_mode = freq_mode_type'(m);
         repeat (2) @(negedge clk);
         expect_now(3'h1, 32'(len_tab[m]));
      end
      // random strobe routing with the reference parked
      run = 1'b0;
      repeat (2) @(negedge clk);
      exp_val[1] = 1'b0; // parked reference selected before the loop
      repeat (40) begin
         rnd = $random(seed);
         {zero_shift, use_ioe_resync, qdr_mode, strobe_in} = rnd[3:0];
         {strobe_shifted, cq_n_shifted, ref_from_pll, ref_pin_clk} = rnd[7:4];
         offset_in = rnd[14:8];
         // selected reference passes two flops, so it shows one step late
         exp_val[0] = exp_val[1];
         exp_val[1] = ref_from_pll ? ref_clk : ref_pin_clk;
         exp_val[10] = zero_shift ? strobe_in : strobe_shifted;
         exp_val[9] = exp_val[10] & ~use_ioe_resync;
         exp_val[8] = cq_n_shifted & qdr_mode;
         @(negedge clk);
         expect_now(3'h0, {21'h0, exp_val[10:8], offset_in, exp_val[0]});
      end
      report_and_stop();
   end
endmodule // test_strobe_dll_delay_control
`default_nettype wire
